/* File: verilog/pcd_phy_regs.sv */
module pcd_phy_regs
  import pcd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mgmt_req,
  input wire logic mgmt_write,
  input wire logic [4:0] phy_select_address,
  input wire logic [4:0] phy_register_address,
  input wire logic [15:0] mgmt_wdata,
  output logic [15:0] mgmt_rdata,
  output logic mgmt_ack,
  output logic mgmt_addr_hit,
  input wire logic [1:0] mirror_wr_en,
  input wire logic [7:0] mirror_wr_ctrl,
  input wire logic [1:0] mirror_diag_start,
  output logic [7:0] mirror_ctrl,
  input wire logic [1:0] diag_done,
  input wire logic [3:0] diag_result,
  input wire logic [1:0] diag_near_short,
  input wire logic [17:0] diag_distance,
  input wire logic [1:0] polarity_reversed,
  input wire logic [1:0] crossover_state,
  input wire logic [1:0] lp_10half,
  output logic [1:0] diag_start,
  output logic [1:0] diag_busy,
  output logic [1:0] force_link,
  output logic [1:0] power_save_en,
  output logic [1:0] remote_loopback
);
  logic [1:0] sel;
  logic [15:0] port_rd [NUM_PORTS];
  logic [15:0] next_rdata;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // other phy addresses belong to other blocks; stay silent for them
  always_comb begin
    sel = 2'b00;
    if (phy_select_address == PHY_ADDR_PORT1) begin
      sel = 2'b01;
    end else if (phy_select_address == PHY_ADDR_PORT2) begin
      sel = 2'b10;
    end
  end

  assign mgmt_addr_hit = |sel;

  // ---------------------------------------------------------------
  // per-port banks
  // ---------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_port
      pcd_port_regs u_port (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(mgmt_req && mgmt_write && sel[p]),
        .wr_reg(phy_register_address),
        .wr_data(mgmt_wdata),
        .mirror_wr_en(mirror_wr_en[p]),
        .mirror_wr_ctrl(mirror_wr_ctrl[4*p+3:4*p]),
        .mirror_diag_start(mirror_diag_start[p]),
        .diag_done(diag_done[p]),
        .diag_result(diag_result[2*p+1:2*p]),
        .diag_near_short(diag_near_short[p]),
        .diag_distance(diag_distance[9*p+8:9*p]),
        .polarity_reversed(polarity_reversed[p]),
        .crossover_state(crossover_state[p]),
        .lp_10half(lp_10half[p]),
        .rd_reg(phy_register_address),
        .rd_data(port_rd[p]),
        .diag_start(diag_start[p]),
        .diag_busy(diag_busy[p]),
        .force_link(force_link[p]),
        .power_save_en(power_save_en[p]),
        .remote_loopback(remote_loopback[p])
      );
      // switch-side view of the same control bits
      assign mirror_ctrl[4*p+3:4*p] = {force_link[p], !power_save_en[p],
          remote_loopback[p], 1'b0};
    end
  endgenerate

  // ---------------------------------------------------------------
  // read answer, one cycle after the request
  // ---------------------------------------------------------------
  always_comb begin
    next_rdata = 16'h0000;
    if (sel[0]) begin
      next_rdata = port_rd[0];
    end else if (sel[1]) begin
      next_rdata = port_rd[1];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mgmt_rdata <= 16'h0000;
      mgmt_ack <= 1'b0;
    end else begin
      mgmt_ack <= mgmt_req && |sel;
      if (mgmt_req && !mgmt_write && |sel) begin
        mgmt_rdata <= next_rdata;
      end
    end
  end
endmodule

/* File: verilog/pcd_pkg.sv */
// Overview of operation
// - phy address 1 or 2 picks a port; reg 0x1D diagnostics, 0x1F special.
// - writing one to diag bit 15 starts a test; hardware clears it when done.
// - host treats start bit zero as done; results valid only then.
// - bits 14-13 give outcome: normal, open, short, or test failed.
// - bit 12 set when the detected short is under ten meters away.
// - bits 8-0 give fault distance, about 0.4 m per count.
// - bit 5 shows reversed polarity (10 Mb/s only); bit 4 one means straight.
// - bit 2 zero enables power saving; resets to one, saving disabled.
// - bit 1 one loops receive pair back out the transmit pair.
// - partner ability bit 5 shows 10 half; bits 4-0 read zero.
package pcd_pkg;
  localparam logic [4:0] PHY_ADDR_PORT1 = 5'h01;
  localparam logic [4:0] PHY_ADDR_PORT2 = 5'h02;
  localparam logic [4:0] REG_LP_ABILITY = 5'h05;
  localparam logic [4:0] REG_CABLE_DIAG = 5'h1d;
  localparam logic [4:0] REG_SPECIAL = 5'h1f;
  localparam int DIAG_START_BIT = 15;
  localparam int DIAG_RESULT_HI = 14;
  localparam int DIAG_RESULT_LO = 13;
  localparam int DIAG_SHORT_BIT = 12;
  localparam int DIAG_DIST_HI = 8;
  localparam int SPC_POLARITY_BIT = 5;
  localparam int SPC_STRAIGHT_BIT = 4;
  localparam int SPC_FORCE_LINK_BIT = 3;
  localparam int SPC_PWR_SAVE_BIT = 2;
  localparam int SPC_LOOPBACK_BIT = 1;
  localparam int SPC_RESERVED_BIT = 0;
  localparam int LP_10HALF_BIT = 5;
  localparam logic [15:0] DIAG_RESET = 16'h0000;
  localparam logic [3:0] SPC_CTRL_RESET = 4'h4;
  localparam logic [1:0] RESULT_NORMAL = 2'h0;
  localparam logic [1:0] RESULT_OPEN = 2'h1;
  localparam logic [1:0] RESULT_SHORT = 2'h2;
  localparam logic [1:0] RESULT_FAILED = 2'h3;
  localparam int NUM_PORTS = 2;
endpackage

/* File: verilog/pcd_port_regs.sv */
module pcd_port_regs
  import pcd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [4:0] wr_reg,
  input wire logic [15:0] wr_data,
  input wire logic mirror_wr_en,
  input wire logic [3:0] mirror_wr_ctrl,
  input wire logic mirror_diag_start,
  input wire logic diag_done,
  input wire logic [1:0] diag_result,
  input wire logic diag_near_short,
  input wire logic [8:0] diag_distance,
  input wire logic polarity_reversed,
  input wire logic crossover_state,
  input wire logic lp_10half,
  input wire logic [4:0] rd_reg,
  output logic [15:0] rd_data,
  output logic diag_start,
  output logic diag_busy,
  output logic force_link,
  output logic power_save_en,
  output logic remote_loopback
);
  logic busy;
  logic [1:0] result;
  logic near_short_flag;
  logic [8:0] distance;
  logic [3:0] ctrl;

  // ---------------------------------------------------------------
  // diagnostic start and results
  // ---------------------------------------------------------------
  // a start while busy is dropped; done only ends a running test
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else if (diag_start) begin
      busy <= 1'b1;
    end else if (busy && diag_done) begin
      busy <= 1'b0;
    end
  end

  // results latch only at completion so reads stay stable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result <= DIAG_RESET[DIAG_RESULT_HI:DIAG_RESULT_LO];
      near_short_flag <= 1'b0;
      distance <= DIAG_RESET[DIAG_DIST_HI:0];
    end else if (busy && diag_done) begin
      result <= diag_result;
      near_short_flag <= diag_near_short
          && diag_result == RESULT_SHORT;
      distance <= diag_distance;
    end
  end

  assign diag_start = !busy && ((wr_en && wr_reg == REG_CABLE_DIAG
      && wr_data[DIAG_START_BIT]) || mirror_diag_start);
  assign diag_busy = busy;

  // ---------------------------------------------------------------
  // special control bits
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= SPC_CTRL_RESET;
    end else if (wr_en && wr_reg == REG_SPECIAL) begin
      ctrl <= wr_data[SPC_FORCE_LINK_BIT:SPC_RESERVED_BIT];
    end else if (mirror_wr_en) begin
      ctrl <= mirror_wr_ctrl;
    end
  end

  assign force_link = ctrl[SPC_FORCE_LINK_BIT];
  assign power_save_en = !ctrl[SPC_PWR_SAVE_BIT];
  assign remote_loopback = ctrl[SPC_LOOPBACK_BIT];

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    rd_data = 16'h0000;
    if (rd_reg == REG_CABLE_DIAG) begin
      rd_data[DIAG_START_BIT] = busy;
      rd_data[DIAG_RESULT_HI:DIAG_RESULT_LO] = result;
      rd_data[DIAG_SHORT_BIT] = near_short_flag;
      rd_data[DIAG_DIST_HI:0] = distance;
    end else if (rd_reg == REG_SPECIAL) begin
      rd_data[SPC_POLARITY_BIT] = polarity_reversed;
      rd_data[SPC_STRAIGHT_BIT] = crossover_state;
      rd_data[SPC_FORCE_LINK_BIT:SPC_RESERVED_BIT] = ctrl;
    end else if (rd_reg == REG_LP_ABILITY) begin
      rd_data[LP_10HALF_BIT] = lp_10half;
    end
  end
endmodule

/* File: bench/pcd_phy_regs_asserts.sv */
module pcd_chk
  import pcd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mgmt_req,
  input wire logic mgmt_write,
  input wire logic mgmt_ack,
  input wire logic mgmt_addr_hit,
  input wire logic [4:0] phy_select_address,
  input wire logic [4:0] phy_register_address,
  input wire logic [15:0] mgmt_wdata,
  input wire logic [15:0] mgmt_rdata,
  input wire logic [1:0] diag_start,
  input wire logic [1:0] diag_busy,
  input wire logic [1:0] diag_done,
  input wire logic [1:0] force_link,
  input wire logic [1:0] power_save_en,
  input wire logic [1:0] remote_loopback
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence wr_to(p, r);
    mgmt_req && mgmt_write && phy_select_address == p &&
      phy_register_address == r;
  endsequence

  ack_after_hit_a: assert property (
    mgmt_req && mgmt_addr_hit |=> mgmt_ack) else $error("ack missing");
  ack_has_cause_a: assert property (
    mgmt_ack |-> $past(mgmt_req && mgmt_addr_hit)) else $error("stray ack");
  rdata_hold_a: assert property (
    $changed(mgmt_rdata) |-> mgmt_ack && !$past(mgmt_write))
    else $error("read data moved");
  addr_decode_a: assert property (
    mgmt_addr_hit == (phy_select_address == PHY_ADDR_PORT1 ||
      phy_select_address == PHY_ADDR_PORT2)) else $error("bad decode");
  diag_launch_a: assert property (
    wr_to(PHY_ADDR_PORT1, REG_CABLE_DIAG) ##0
      mgmt_wdata[DIAG_START_BIT] && !diag_busy[0]
      |-> diag_start[0] ##1 diag_busy[0]) else $error("test not started");
  diag_finish_a: assert property (
    diag_busy[0] && diag_done[0] |=> !diag_busy[0]) else $error("busy stuck");
  spc_port_one_a: assert property (
    wr_to(PHY_ADDR_PORT1, REG_SPECIAL) |=> power_save_en[0] !=
      $past(mgmt_wdata[SPC_PWR_SAVE_BIT]) &&
      force_link[0] == $past(mgmt_wdata[SPC_FORCE_LINK_BIT]))
    else $error("port one control wrong");
  loop_port_two_a: assert property (
    wr_to(PHY_ADDR_PORT2, REG_SPECIAL) |=> remote_loopback[1] ==
      $past(mgmt_wdata[SPC_LOOPBACK_BIT])) else $error("loopback wrong");
endmodule

bind pcd_phy_regs pcd_chk chk_u (
  .clk(clk),
  .rst_n(rst_n),
  .mgmt_req(mgmt_req),
  .mgmt_write(mgmt_write),
  .mgmt_ack(mgmt_ack),
  .mgmt_addr_hit(mgmt_addr_hit),
  .phy_select_address(phy_select_address),
  .phy_register_address(phy_register_address),
  .mgmt_wdata(mgmt_wdata),
  .mgmt_rdata(mgmt_rdata),
  .diag_start(diag_start),
  .diag_busy(diag_busy),
  .diag_done(diag_done),
  .force_link(force_link),
  .power_save_en(power_save_en),
  .remote_loopback(remote_loopback)
);

/* File: bench/pcd_host.sv */
module pcd_host
  import pcd_pkg::*;
(
  input wire logic clk,
  input wire logic mgmt_ack,
  input wire logic [15:0] mgmt_rdata,
  output logic mgmt_req = 1'b0,
  output logic mgmt_write = 1'b0,
  output logic [4:0] phy_select_address = 5'h00,
  output logic [4:0] phy_register_address = 5'h00,
  output logic [15:0] mgmt_wdata = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ps;
  // released lines show the inverse, except phy_register_address, which keeps the last value
  task xfer(input logic w, input logic [4:0] p, r, input logic [15:0] d,
            output logic [15:0] q, output logic got);
    int n;
    got = 0;
    q = 16'h0000;
    @(posedge clk);
    mgmt_req <= 1;
    mgmt_write <= w;
    phy_select_address <= p;
    phy_register_address <= r;
    mgmt_wdata <= (r == REG_SPECIAL) ? d & 16'hfffe : d;
    @(posedge clk);
    mgmt_req <= 0;
    mgmt_write <= ~w;
    phy_select_address <= ~p;
    mgmt_wdata <= ~d;
    for (n = 0; n < 4 && !got; n++) begin
      @(posedge clk);
      if (mgmt_ack === 1'b1) begin
        got = 1;
        q = mgmt_rdata;
      end
    end
  endtask
endmodule

/* File: bench/pcd_phy_regs_test.sv */
module pcd_phy_regs_test
  import pcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, mgmt_req, mgmt_write, mgmt_ack, mgmt_addr_hit;
  logic [4:0] phy_select_address, phy_register_address;
  logic [15:0] mgmt_wdata, mgmt_rdata;
  logic [1:0] mirror_wr_en = 0, mirror_diag_start = 0, diag_done = 0;
  logic [1:0] diag_near_short = 0, polarity_reversed = 2'h2;
  logic [1:0] crossover_state = 2'h1, lp_10half = 2'h1;
  logic [1:0] diag_start, diag_busy, force_link, power_save_en;
  logic [1:0] remote_loopback;
  logic [7:0] mirror_wr_ctrl = 0, mirror_ctrl;
  logic [3:0] diag_result = 0;
  logic [17:0] diag_distance = 0;
  int n_fail = 0, num_checks = 0;
  pcd_phy_regs dut_u (
    .clk(clk),
    .rst_n(rst_n),
    .mgmt_req(mgmt_req),
    .mgmt_write(mgmt_write),
    .phy_select_address(phy_select_address),
    .phy_register_address(phy_register_address),
    .mgmt_wdata(mgmt_wdata),
    .mgmt_rdata(mgmt_rdata),
    .mgmt_ack(mgmt_ack),
    .mgmt_addr_hit(mgmt_addr_hit),
    .mirror_wr_en(mirror_wr_en),
    .mirror_wr_ctrl(mirror_wr_ctrl),
    .mirror_diag_start(mirror_diag_start),
    .mirror_ctrl(mirror_ctrl),
    .diag_done(diag_done),
    .diag_result(diag_result),
    .diag_near_short(diag_near_short),
    .diag_distance(diag_distance),
    .polarity_reversed(polarity_reversed),
    .crossover_state(crossover_state),
    .lp_10half(lp_10half),
    .diag_start(diag_start),
    .diag_busy(diag_busy),
    .force_link(force_link),
    .power_save_en(power_save_en),
    .remote_loopback(remote_loopback)
  );
  pcd_host host_u (
    .clk(clk),
    .mgmt_ack(mgmt_ack),
    .mgmt_rdata(mgmt_rdata),
    .mgmt_req(mgmt_req),
    .mgmt_write(mgmt_write),
    .phy_select_address(phy_select_address),
    .phy_register_address(phy_register_address),
    .mgmt_wdata(mgmt_wdata)
  );
  always #5 clk = ~clk;
  task chk(input string nm, input logic [15:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task chk_ack(input string nm, input logic e, g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask
  task acc(input logic w, input logic [4:0] p, r, input logic [15:0] d);
    logic [15:0] q;
    logic got;
    host_u.xfer(w, p, r, d, q, got);
    if (w) begin
      chk_ack("ack", 1'b1, got);
    end else begin
      chk("rdata", d, q);
    end
  endtask
  task t_reset;
    acc(0, 1, REG_LP_ABILITY, 16'h0020);
    acc(0, 2, REG_LP_ABILITY, 16'h0000);
    acc(0, 1, REG_SPECIAL, 16'h0014);
    acc(0, 2, REG_SPECIAL, 16'h0024);
  endtask
  task t_ctrl;
    acc(1, 1, REG_SPECIAL, 16'h0000);
    acc(1, 2, REG_SPECIAL, 16'h000b);
    acc(0, 2, REG_SPECIAL, 16'h002a);
    chk("ctl", 16'h002e,
        16'({force_link, power_save_en, remote_loopback}));
  endtask
  // results of the previous test stay visible while a new one runs
  task t_diag;
    logic [15:0] seen;
    seen = 16'h0000;
    for (int k = 0; k < 4; k++) begin
      acc(1, 1, REG_CABLE_DIAG, 16'h8000);
      acc(0, 1, REG_CABLE_DIAG, 16'h8000 | seen);
      diag_result <= 4'(k);
      diag_near_short <= 2'h1;
      diag_distance <= {9'h000, 2'(k), 7'h7f};
      diag_done <= 2'h1;
      @(posedge clk);
      diag_done <= 2'h0;
      seen = {1'b0, 2'(k), k == 2, 3'h0, 2'(k), 7'h7f};
      acc(0, 1, REG_CABLE_DIAG, seen);
    end
  endtask
  task t_refuse;
    logic [15:0] q;
    logic got;
    host_u.xfer(1, 5'h03, REG_SPECIAL, 16'h0008, q, got);
    chk_ack("no ack", 1'b0, got);
    acc(0, 1, REG_SPECIAL, 16'h0010);
  endtask
  task t_mirror;
    @(posedge clk);
    mirror_diag_start <= 2'h2;
    mirror_wr_en <= 2'h1;
    mirror_wr_ctrl <= 8'h0c;
    @(posedge clk);
    mirror_diag_start <= 2'h0;
    mirror_wr_en <= 2'h0;
    acc(0, 2, REG_CABLE_DIAG, 16'h8000);
    acc(0, 1, REG_SPECIAL, 16'h001c);
    chk("mirror", 16'h00ac, 16'(mirror_ctrl));
    chk("busy", 16'h0002, 16'(diag_busy));
  endtask
  task end_of_test;
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1;
    t_reset();
    t_ctrl();
    t_diag();
    t_refuse();
    t_mirror();
    end_of_test();
  end
  // whole run is about a hundred cycles; generous margin
  initial begin
    #30us;
    n_fail++;
    end_of_test();
  end
endmodule
